// [verilog/spi_pkg.sv]
// ----------------------------------------
// shared constants for the serial controller
// ----------------------------------------
`default_nettype none
package spi_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  localparam logic [7:0] OFS_EN   = 8'h10;
  localparam logic [7:0] OFS_DLY  = 8'h14;
  localparam logic [7:0] OFS_DMA  = 8'h18;
  // control bit positions
  localparam int B_TX_FLUSH = 20;
  localparam int B_RX_FLUSH = 19;
  localparam int B_DTX_IE   = 18;
  localparam int B_DRX_IE   = 17;
  localparam int B_SSC_IE   = 16;
  localparam int B_TX_IE    = 15;
  localparam int B_RX_IE    = 14;
  localparam int B_SEL_MAN  = 13;
  localparam int B_SEL_LVL  = 12;
  localparam int B_LOOP     = 11;
  localparam int B_SEL_IGN  = 10;
  localparam int B_SEL_OE   = 9;
  localparam int B_SEL_POL  = 8;
  localparam int B_MASTER   = 5;
  localparam int B_MSB      = 4;
  localparam int B_CLOCK_PHASE     = 3;
  localparam int B_CLOCK_POLARITY     = 2;
  // status bit positions
  localparam int S_DTX  = 9;
  localparam int S_DRX  = 8;
  localparam int S_EDGE = 6;
  localparam int S_SEL  = 5;
  localparam int S_OVR  = 4;
  localparam int S_UDR  = 3;
  localparam int S_IDLE = 2;
  localparam int S_TX_BUFFER_READY = 1;
  localparam int S_RX_BUFFER_FULL = 0;
  // delay field low bits
  localparam int L_STOP  = 16;
  localparam int L_BURST = 8;
  localparam int L_START = 0;
  // reset values and masks
  localparam logic [19:0] CTRL_RST  = 20'h01020;
  localparam logic [19:0] CTRL_MASK = 20'h7ff3f;
  localparam logic [15:0] BAUD_RST  = 16'h00ff;
  localparam logic [23:0] DLY_RST   = 24'h010101;
  // frame widths in bits
  localparam logic [4:0] W8  = 5'h08;
  localparam logic [4:0] W9  = 5'h09;
  localparam logic [4:0] W16 = 5'h10;
  localparam logic [4:0] W17 = 5'h11;
  // shifter sequence
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_SHIFT, ST_BURST, ST_STOP
  } state_t;
endpackage
`default_nettype wire

// [verilog/spi_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module spi_ctrl #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  // serial clock pin
  input  wire logic              sclk_in,
  output logic                   sclk_out,
  output logic                   sclk_oe,
  // master-out data pin
  input  wire logic              mosi_in,
  output logic                   mosi_out,
  output logic                   mosi_oe,
  // master-in data pin
  input  wire logic              miso_in,
  output logic                   miso_out,
  output logic                   miso_oe,
  // select pin
  input  wire logic              ss_in,
  output logic                   ss_out,
  output logic                   ss_oe,
  // interrupt request
  output logic                   irq,
  // dma handshake
  output logic                   dma_tx_req,
  input  wire logic              dma_tx_ack,
  input  wire logic              dma_tx_done,
  output logic                   dma_rx_req,
  input  wire logic              dma_rx_ack,
  input  wire logic              dma_rx_done
);
  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // width code to bit count
  function automatic logic [4:0] fw_bits(input logic [1:0] c);
    case (c)
      2'h0:    fw_bits = spi_pkg::W8;
      2'h1:    fw_bits = spi_pkg::W9;
      2'h2:    fw_bits = spi_pkg::W16;
      default: fw_bits = spi_pkg::W17;
    endcase
  endfunction

  // bit position of the cnt-th bit on the wire
  function automatic logic [4:0] bit_idx(input logic [4:0] cnt,
                                         input logic [4:0] w,
                                         input logic       msb);
    if (cnt >= w)
      bit_idx = 5'h00;
    else if (msb)
      bit_idx = w - 5'h01 - cnt;
    else
      bit_idx = cnt;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    spi_pkg::state_t st;       // shifter sequence
    logic [19:0]     ctrl;     // control register
    logic [15:0]     baud;     // divider
    logic            en;       // unit enable
    logic [23:0]     dly;      // stop/burst/start
    logic [1:0]      dma_en;   // bit0 tx, bit1 rx
    logic [16:0]     tx_buf;   // transmit buffer
    logic            tx_full;  // buffer holds data
    logic [16:0]     tx_sh;    // frame being sent
    logic [16:0]     rx_sh;    // frame being built
    logic [16:0]     rx_buf;   // receive buffer
    logic            rx_full;  // buffer holds data
    logic            edge_seen;
    logic            ovr;
    logic            udr;
    logic            dtx_cpl;
    logic            drx_cpl;
    logic [15:0]     div;      // divider count
    logic            sck_act;  // clock in active half
    logic [4:0]      dcnt;     // bits driven
    logic [4:0]      scnt;     // bits sampled
    logic [7:0]      wcnt;     // delay countdown
    logic            sck_prev; // last slave clock
    logic            sel;      // last select state
    logic            dtx_req;
    logic            drx_req;
    logic            dtx_wait; // acked, wait refill
    logic            drx_wait; // acked, wait drain
    logic            sclk_out;
    logic            sclk_oe;
    logic            mosi_out;
    logic            mosi_oe;
    logic            miso_out;
    logic            miso_oe;
    logic            ss_out;
    logic            ss_oe;
    logic            irq;
    logic [31:0]     rdata;
  } regs_t;

  regs_t r;       // registered state
  regs_t n;       // next state

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  logic        master;    // role select
  logic        clock_phase;      // clock phase
  logic        clock_polarity;      // clock polarity
  logic        msb;       // bit order
  logic        pol;       // select active level
  logic        ign;       // slave ignores select
  logic [4:0]  wbits;     // frame length
  logic [16:0] wmask;     // frame bit mask
  logic [15:0] half;      // divider mid point
  logic        shifting;  // in the shift state
  logic        s_lead;    // slave clock to active
  logic        s_trail;   // slave clock to idle
  logic        lead;      // idle-to-active edge
  logic        trail;     // active-to-idle edge
  logic        sample;    // capture edge
  logic        drive;     // change edge
  logic        din;       // received bit
  logic [4:0]  ridx;      // capture position
  logic [16:0] rx_new;    // frame with new bit
  logic [4:0]  scnt_nx;   // sampled after edge
  logic        done;      // frame complete
  logic        ss_act;    // select pin active
  logic        slv_sel;   // slave is selected
  logic        sel_now;   // select state now
  logic        wr_data;   // write to data reg
  logic        rd_data;   // read of data reg
  logic        wr_en;     // write to enable reg
  logic        wrap;      // divider period end

  assign master   = r.ctrl[spi_pkg::B_MASTER];
  assign clock_phase     = r.ctrl[spi_pkg::B_CLOCK_PHASE];
  assign clock_polarity     = r.ctrl[spi_pkg::B_CLOCK_POLARITY];
  assign msb      = r.ctrl[spi_pkg::B_MSB];
  assign pol      = r.ctrl[spi_pkg::B_SEL_POL];
  assign ign      = r.ctrl[spi_pkg::B_SEL_IGN];
  assign wbits    = fw_bits(r.ctrl[1:0]);
  assign wmask    = 17'h1ffff >> (spi_pkg::W17 - wbits);
  // a divider of zero leaves no room for a mid point
  assign half     = r.baud >> 1;
  assign shifting = r.st == spi_pkg::ST_SHIFT;
  assign wrap     = r.div == r.baud;
  // active clock level is the inverse of polarity
  assign s_lead   = (sclk_in != r.sck_prev) && (sclk_in != clock_polarity);
  assign s_trail  = (sclk_in != r.sck_prev) && (sclk_in == clock_polarity);
  assign lead     = shifting && (master ? r.div == half : s_lead);
  assign trail    = shifting && (master ? wrap : s_trail);
  // phase 0 samples on the first edge, phase 1 on the second
  assign sample   = clock_phase ? trail : lead;
  assign drive    = clock_phase ? lead : trail;
  assign din      = master ? (r.ctrl[spi_pkg::B_LOOP] ? r.mosi_out
                                                      : miso_in)
                           : mosi_in;
  assign ridx     = bit_idx(r.scnt, wbits, msb);
  assign rx_new   = (r.rx_sh & ~(17'h00001 << ridx))
                  | ({16'h0000, din} << ridx);
  assign scnt_nx  = sample ? r.scnt + 5'h01 : r.scnt;
  assign done     = trail && scnt_nx == wbits;
  assign ss_act   = ss_in == pol;
  assign slv_sel  = ign | ss_act;
  assign sel_now  = master ? r.ss_out == pol : ss_act;
  assign wr_data  = wr && addr == spi_pkg::OFS_DATA;
  assign rd_data  = rd && addr == spi_pkg::OFS_DATA;
  assign wr_en    = wr && addr == spi_pkg::OFS_EN;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [4:0] dpos;
    dpos = 5'h00;
    n = r;
    n.rdata = 32'h00000000;
    n.sck_prev = sclk_in;
    n.sel = sel_now;
    // software writes; clears come before hardware sets
    if (wr) begin
      case (addr)
        spi_pkg::OFS_DATA: begin
          n.tx_buf  = wdata[16:0];
          n.tx_full = 1'b1;
          n.ovr     = 1'b0;
          n.udr     = 1'b0;
        end
        spi_pkg::OFS_CTRL: begin
          n.ctrl = wdata[19:0] & spi_pkg::CTRL_MASK;
          // flush strobes act once and are not stored
          if (wdata[spi_pkg::B_TX_FLUSH]) begin
            n.tx_full = 1'b0;
          end
          if (wdata[spi_pkg::B_RX_FLUSH]) begin
            n.rx_full = 1'b0;
          end
        end
        spi_pkg::OFS_STAT: begin
          // only the edge flag clears by writing zero
          if (!wdata[spi_pkg::S_EDGE]) begin
            n.edge_seen = 1'b0;
          end
        end
        spi_pkg::OFS_BAUD: n.baud = wdata[15:0];
        spi_pkg::OFS_EN: begin
          n.en = wdata[0];
          // enabling sends whatever the buffer holds
          if (wdata[0] && !r.en) begin
            n.tx_full = 1'b1;
          end
        end
        spi_pkg::OFS_DLY: n.dly = wdata[23:0];
        spi_pkg::OFS_DMA: n.dma_en = wdata[1:0];
        default: ;  // unmapped writes are dropped
      endcase
    end
    // register reads; unmapped reads return zero
    if (rd) begin
      case (addr)
        spi_pkg::OFS_DATA: begin
          n.rdata   = {15'h0000, r.rx_buf};
          n.rx_full = 1'b0;
          n.ovr     = 1'b0;
          n.udr     = 1'b0;
        end
        spi_pkg::OFS_CTRL: n.rdata = {12'h000, r.ctrl};
        spi_pkg::OFS_STAT: begin
          n.rdata[spi_pkg::S_DTX]  = r.dtx_cpl;
          n.rdata[spi_pkg::S_DRX]  = r.drx_cpl;
          n.rdata[spi_pkg::S_EDGE] = r.edge_seen;
          n.rdata[spi_pkg::S_SEL]  = r.sel;
          n.rdata[spi_pkg::S_OVR]  = r.ovr;
          n.rdata[spi_pkg::S_UDR]  = r.udr;
          n.rdata[spi_pkg::S_IDLE] = r.st == spi_pkg::ST_IDLE;
          n.rdata[spi_pkg::S_TX_BUFFER_READY] = !r.tx_full;
          n.rdata[spi_pkg::S_RX_BUFFER_FULL] = r.rx_full;
        end
        spi_pkg::OFS_BAUD: n.rdata = {16'h0000, r.baud};
        spi_pkg::OFS_EN:   n.rdata = {31'h00000000, r.en};
        spi_pkg::OFS_DLY:  n.rdata = {8'h00, r.dly};
        spi_pkg::OFS_DMA:  n.rdata = {30'h00000000, r.dma_en};
        default: ;
      endcase
    end
    // select edge sets the flag; set wins over a status-write clear, disable wins over set
    if (sel_now != r.sel) begin
      n.edge_seen = 1'b1;
    end
    // ----------------------------------------
    // shifter sequence
    // ----------------------------------------
    case (r.st)
      spi_pkg::ST_IDLE: begin
        n.sck_act = 1'b0;
        n.div = 16'h0000;
        n.dcnt = 5'h00;
        n.scnt = 5'h00;
        if (r.en && master && r.tx_full) begin
          n.tx_sh = r.tx_buf;
          n.tx_full = wr_data;
          n.wcnt = r.dly[spi_pkg::L_START +: 8];
          n.st = spi_pkg::ST_START;
        end else if (r.en && !master && slv_sel) begin
          // stale frame goes out if nothing was loaded
          n.tx_sh = r.tx_buf;
          n.tx_full = wr_data;
          n.udr = n.udr | !r.tx_full;
          n.st = spi_pkg::ST_SHIFT;
        end
      end
      spi_pkg::ST_START, spi_pkg::ST_BURST,
      spi_pkg::ST_STOP: begin
        // delays count whole serial clock periods
        n.div = wrap ? 16'h0000 : r.div + 16'h0001;
        if (wrap) begin
          if (r.wcnt <= 8'h01) begin
            n.st = (r.st == spi_pkg::ST_STOP) ? spi_pkg::ST_IDLE
                                               : spi_pkg::ST_SHIFT;
          end else begin
            n.wcnt = r.wcnt - 8'h01;
          end
        end
      end
      spi_pkg::ST_SHIFT: begin
        if (master) begin
          n.div = wrap ? 16'h0000 : r.div + 16'h0001;
          // first half of each bit stays at idle level
          if (lead) begin
            n.sck_act = 1'b1;
          end
          if (trail) begin
            n.sck_act = 1'b0;
          end
        end
        if (drive) begin
          n.dcnt = r.dcnt + 5'h01;
        end
        if (sample) begin
          n.rx_sh = rx_new;
          n.scnt = scnt_nx;
        end
        if (done) begin
          n.rx_buf = rx_new & wmask;
          n.rx_full = 1'b1;
          // previous frame still unread
          if (r.rx_full && !rd_data) begin
            n.ovr = 1'b1;
          end
          n.dcnt = 5'h00;
          n.scnt = 5'h00;
          if (master) begin
            n.div = 16'h0000;
            if (r.tx_full) begin
              n.tx_sh = r.tx_buf;
              n.tx_full = wr_data;
              n.wcnt = r.dly[spi_pkg::L_BURST +: 8];
              n.st = spi_pkg::ST_BURST;
            end else begin
              n.wcnt = r.dly[spi_pkg::L_STOP +: 8];
              n.st = spi_pkg::ST_STOP;
            end
          end else begin
            n.tx_sh = r.tx_buf;
            n.tx_full = wr_data;
            n.udr = n.udr | !r.tx_full;
          end
        end
        // slave frame aborts when select drops
        if (!master && !slv_sel) begin
          n.st = spi_pkg::ST_IDLE;
        end
      end
      default: n.st = spi_pkg::ST_IDLE;
    endcase
    // ----------------------------------------
    // dma handshake
    // ----------------------------------------
    // a request waits for its acknowledge and a refill (tx) or a drain (rx)
    if (r.dtx_req && dma_tx_ack) begin
      n.dtx_req = 1'b0;
      n.dtx_wait = 1'b1;
    end
    if (r.dtx_wait && n.tx_full) begin
      n.dtx_wait = 1'b0;
    end
    if (n.en && r.dma_en[0] && !n.tx_full && !r.dtx_req
        && !r.dtx_wait) begin
      n.dtx_req = 1'b1;
      n.dtx_cpl = 1'b0;
    end
    if (r.drx_req && dma_rx_ack) begin
      n.drx_req = 1'b0;
      n.drx_wait = 1'b1;
    end
    if (r.drx_wait && !n.rx_full) begin
      n.drx_wait = 1'b0;
    end
    if (n.en && r.dma_en[1] && n.rx_full && !r.drx_req
        && !r.drx_wait) begin
      n.drx_req = 1'b1;
      n.drx_cpl = 1'b0;
    end
    if (!r.dma_en[0]) begin
      n.dtx_cpl = 1'b0;
      n.dtx_req = 1'b0;
    end
    if (!r.dma_en[1]) begin
      n.drx_cpl = 1'b0;
      n.drx_req = 1'b0;
    end
    if (dma_tx_done && r.dma_en[0]) begin
      n.dtx_cpl = 1'b1;
    end
    if (dma_rx_done && r.dma_en[1]) begin
      n.drx_cpl = 1'b1;
    end
    // disabling returns status to reset, keeps setup
    if (wr_en && !wdata[0]) begin
      n.st = spi_pkg::ST_IDLE;
      n.tx_full = 1'b0;
      n.rx_full = 1'b0;
      n.edge_seen = 1'b0;
      n.ovr = 1'b0;
      n.udr = 1'b0;
      n.dtx_cpl = 1'b0;
      n.drx_cpl = 1'b0;
      n.dtx_req = 1'b0;
      n.drx_req = 1'b0;
      n.dtx_wait = 1'b0;
      n.drx_wait = 1'b0;
      n.sck_act = 1'b0;
    end
    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // phase 1 presents bit k-1 after the k-th lead edge
    if (clock_phase) begin
      dpos = (n.dcnt == 5'h00) ? 5'h00 : n.dcnt - 5'h01;
    end else begin
      dpos = n.dcnt;
    end
    n.mosi_out = n.tx_sh[bit_idx(dpos, wbits, msb)];
    n.miso_out = n.mosi_out;
    n.sclk_out = clock_polarity ^ n.sck_act;
    n.sclk_oe = n.en & master;
    n.mosi_oe = n.en & master;
    n.miso_oe = n.en & !master & slv_sel;
    if (n.ctrl[spi_pkg::B_SEL_MAN]) begin
      n.ss_out = n.ctrl[spi_pkg::B_SEL_LVL];
    end else begin
      n.ss_out = (n.st != spi_pkg::ST_IDLE && master) ? pol : !pol;
    end
    n.ss_oe = n.ctrl[spi_pkg::B_SEL_OE];
    n.irq = n.en & |{n.edge_seen & n.ctrl[spi_pkg::B_SSC_IE],
                     !n.tx_full & n.ctrl[spi_pkg::B_TX_IE],
                     n.rx_full & n.ctrl[spi_pkg::B_RX_IE],
                     n.drx_cpl & n.ctrl[spi_pkg::B_DRX_IE],
                     n.dtx_cpl & n.ctrl[spi_pkg::B_DTX_IE]};
    // synchronous reset overrides everything
    if (sys_rst) begin
      n = '0;
      n.ctrl = spi_pkg::CTRL_RST;
      n.baud = spi_pkg::BAUD_RST;
      n.dly = spi_pkg::DLY_RST;
      n.ss_out = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    r <= n;
  end

  // outputs straight from flops
  assign rdata      = r.rdata;
  assign sclk_out   = r.sclk_out;
  assign sclk_oe    = r.sclk_oe;
  assign mosi_out   = r.mosi_out;
  assign mosi_oe    = r.mosi_oe;
  assign miso_out   = r.miso_out;
  assign miso_oe    = r.miso_oe;
  assign ss_out     = r.ss_out;
  assign ss_oe      = r.ss_oe;
  assign irq        = r.irq;
  assign dma_tx_req = r.dtx_req;
  assign dma_rx_req = r.drx_req;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_disable_status: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_en && !wdata[0] |=> !r.rx_full && !r.tx_full && !r.ovr
                           && r.st == spi_pkg::ST_IDLE)
    else $error("disable left status set");
  a_flush_tx: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr && addr == spi_pkg::OFS_CTRL && wdata[spi_pkg::B_TX_FLUSH]
    |=> !r.tx_full)
    else $error("tx flush ignored");
  a_edge_flag_set: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    sel_now != r.sel && !wr_en |=> r.edge_seen)
    else $error("select edge not flagged");
  a_overrun_set: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    done && r.rx_full && !rd_data && !wr_en |=> r.ovr)
    else $error("overrun not flagged");
  a_manual_select: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    r.ctrl[spi_pkg::B_SEL_MAN] && !wr ##1 !wr
    |=> ss_out == $past(r.ctrl[spi_pkg::B_SEL_LVL], 2))
    else $error("manual select level wrong");
  a_select_oe_off: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !r.ctrl[spi_pkg::B_SEL_OE] && !wr |=> !ss_oe)
    else $error("select driven while disabled");
  a_idle_status: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rd && addr == spi_pkg::OFS_STAT
    |=> rdata[spi_pkg::S_IDLE] == ($past(r.st) == spi_pkg::ST_IDLE)
        && rdata[spi_pkg::S_TX_BUFFER_READY] == !$past(r.tx_full))
    else $error("status idle or ready wrong");
  a_sclk_idle: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    master && r.st == spi_pkg::ST_START && !wr
    |=> sclk_out == $past(clock_polarity))
    else $error("clock left idle level early");
  a_dma_one_req: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    r.dtx_req && dma_tx_ack |=> !r.dtx_req ##1 !r.dtx_req || r.tx_full)
    else $error("dma request repeated without refill");
endmodule
`default_nettype wire

// [testbench/spi_peer.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------
// far-side peripheral, mode 0
// ---------------------------
module spi_peer (
  input  wire logic       clk_sys,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic [7:0] pat,
  output logic            miso,
  output logic      [7:0] got
);
  logic       s_q;          // delayed serial clock
  logic [2:0] n    = 3'h0;  // bit index
  logic       last = 1'b0;  // last driven bit
  // sample on rise, change on fall, 8-bit lsb first
  always @(posedge clk_sys) begin
    s_q <= sclk;
    if (ss_n) n <= 3'h0;
    else if (s_q & ~sclk) n <= n + 3'h1;
    if (~s_q & sclk & ~ss_n) got <= {mosi, got[7:1]};
    if (!ss_n) last <= miso;
  end
  // released line inverts, so a stale bit never passes
  assign miso = ss_n ? ~last : pat[n];
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------
  // bus and pins
  // ----------------
  logic        clk_sys, sys_rst, wr, rd, sclk_out, sclk_oe, mosi_out;
  logic        mosi_oe, miso_out, miso_oe, ss_out, ss_oe, pm, ss_n;
  logic        dq, dr, dack, irq;
  logic [7:0]  addr, pat, got;
  logic [31:0] wdata, rdata, v, tx;
  integer      seed, mismatches, n_compared, i;
  integer      cyc = 0;
  // undriven select is pulled up
  assign ss_n = ss_oe ? ss_out : 1'b1;
  spi_ctrl u_dut (.clk_sys, .sys_rst, .addr, .wdata, .wr, .rd, .rdata,
    .sclk_in(sclk_out), .sclk_out, .sclk_oe, .mosi_in(mosi_out),
    .mosi_out, .mosi_oe, .miso_in(pm), .miso_out, .miso_oe,
    .ss_in(ss_n), .ss_out, .ss_oe, .irq, .dma_tx_req(dq),
    .dma_tx_ack(dack), .dma_tx_done(1'b0), .dma_rx_req(dr),
    .dma_rx_ack(1'b0), .dma_rx_done(1'b0));
  spi_peer u_peer (.clk_sys, .sclk(sclk_out), .mosi(mosi_out), .ss_n,
    .pat, .miso(pm), .got);
  task automatic conclude;
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // read; a zero mask only fetches into v
  task automatic rdr(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
    if (m !== 32'h0) chk(v & m, e);
  endtask
  // poll idle flag, bounded
  task automatic idle_wait;
    repeat (4) @(posedge clk_sys);
    rdr(8'h08, 32'h0, 32'h0);
    for (int k = 0; k < 300 && v[2] !== 1'b1; k++) rdr(8'h08, 0, 0);
  endtask
  // frame mask per width code
  function automatic logic [31:0] fmask(input int c);
    case (c)
      0: fmask = 32'hff;
      1: fmask = 32'h1ff;
      2: fmask = 32'hffff;
      default: fmask = 32'h1ffff;
    endcase
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    seed = 32'hb187f993;
    {mismatches, n_compared} = 0;
    {sys_rst, wr, rd, dack, addr, wdata} = {1'b1, 43'h0};
    pat = $random(seed);
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdr(8'h04, '1, 32'h1020);
    rdr(8'h08, '1, 32'h6);
    rdr(8'h0c, '1, 32'hff);
    rdr(8'h14, '1, 32'h10101);
    rdr(8'h1c, '1, 32'h0);
    // master, select driven, mode 0, 8-bit lsb first
    wrr(8'h0c, 32'h5);
    wrr(8'h04, 32'h220);
    tx = $random(seed) & 32'hff;
    wrr(8'h00, tx);
    wrr(8'h10, 32'h1);
    idle_wait;
    rdr(8'h08, 32'h7, 32'h7);
    chk({24'h0, got}, tx);
    rdr(8'h00, '1, {24'h0, pat});
    rdr(8'h08, 32'h1, 32'h0);
    chk({29'h0, sclk_oe, mosi_oe, miso_oe}, 32'h6);
    // loopback, msb first, every width code
    for (i = 0; i < 4; i++) begin
      wrr(8'h04, 32'ha30 | 32'(i));
      tx = $random(seed) & fmask(i);
      wrr(8'h00, tx);
      idle_wait;
      rdr(8'h00, '1, tx);
    end
    // two frames left unread: overrun, then rx flush
    wrr(8'h00, tx);
    idle_wait;
    wrr(8'h00, tx);
    idle_wait;
    rdr(8'h08, 32'h11, 32'h11);
    wrr(8'h04, 32'h80a33);
    rdr(8'h08, 32'h11, 32'h10);
    rdr(8'h00, 32'h0, 32'h0);
    rdr(8'h08, 32'h10, 32'h0);
    wrr(8'h04, 32'h3220);
    repeat (2) @(negedge clk_sys);
    chk({ss_oe, ss_out}, 32'h3);
    wrr(8'h04, 32'h2220);
    repeat (2) @(negedge clk_sys);
    chk({ss_oe, ss_out}, 32'h2);
    wrr(8'h04, 32'h20);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, ss_oe}, 32'h0);
    // edge irq: clear the flag, then a manual select edge sets it
    wrr(8'h04, 32'h10020);
    wrr(8'h08, 32'h0);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wrr(8'h04, 32'h12020);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    rdr(8'h08, 32'h60, 32'h60);
    wrr(8'h04, 32'h8020);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    // dma: empty tx asks once, ack retires it until a refill
    wrr(8'h18, 32'h3);
    repeat (2) @(negedge clk_sys);
    chk({30'h0, dq, dr}, 32'h2);
    @(posedge clk_sys) dack <= 1'b1;
    @(posedge clk_sys) dack <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({30'h0, dq, dr}, 32'h0);
    wrr(8'h10, 32'h0);
    rdr(8'h08, '1, 32'h6);
    rdr(8'h04, '1, 32'h8020);
    // disabled unit: tx flush, then slave with select ignored
    tx = $random(seed) & 32'hff;
    wrr(8'h00, tx);
    rdr(8'h08, 32'h2, 32'h0);
    wrr(8'h04, 32'h100400);
    rdr(8'h08, 32'h2, 32'h2);
    wrr(8'h00, tx);
    wrr(8'h10, 32'h1);
    repeat (2) @(negedge clk_sys);
    chk({28'h0, sclk_oe, mosi_oe, miso_oe, miso_out}, {31'h1, tx[0]});
    conclude;
  end
endmodule
`default_nettype wire
